/* File: core/wcr_params.svh */
`ifndef WCR_PARAMS_SVH
`define WCR_PARAMS_SVH

// register offsets
`define WCR_ADDR_CHAN_ALERT_EN 8'h34
`define WCR_ADDR_BLOCK_EN 8'h37
`define WCR_ADDR_CH0_HI_BOT 8'h38
`define WCR_ADDR_CH0_HI_TOP 8'h39
`define WCR_ADDR_CH0_LO_BOT 8'h3A
`define WCR_ADDR_CH0_LO_TOP 8'h3B
`define WCR_ADDR_CH1_HI_BOT 8'h3C
`define WCR_ADDR_CH1_HI_TOP 8'h3D
`define WCR_ADDR_CH1_LO_BOT 8'h3E
`define WCR_ADDR_CH1_LO_TOP 8'h3F
`define WCR_ADDR_CH0_HYS 8'h40
`define WCR_ADDR_CH1_HYS 8'h41

// field positions
`define WCR_BIT_FIRST_ALERT 0
`define WCR_BIT_SECOND_ALERT 1
`define WCR_BIT_BLOCK_ON 0
`define WCR_TOP_MSB 3
`define WCR_HYS_MSB 5

// reset values
`define WCR_RST_ALERT_EN 2'h0
`define WCR_RST_BLOCK_EN 1'h0
`define WCR_RST_LIMIT_TOP 4'h0
`define WCR_RST_LIMIT_BOT 8'h00
`define WCR_RST_HYS 6'h00
`define WCR_RST_RDATA 8'h00

`endif

/* File: core/wcr_pkg.sv */
`default_nettype none
package wcr_pkg;

    typedef logic [7:0] wcr_byte_t;
    typedef logic [11:0] wcr_limit_t;
    typedef logic [5:0] wcr_hys_t;

    // settings that one channel's comparators use
    typedef struct packed {
        logic alert_on;
        wcr_limit_t upper_limit;
        wcr_limit_t lower_limit;
        wcr_hys_t hysteresis;
    } wcr_chan_cfg_s;

    // one register access from the serial front end
    typedef struct packed {
        logic wr;
        logic rd;
        wcr_byte_t addr;
        wcr_byte_t wdata;
    } wcr_req_s;

endpackage

`default_nettype wire

/* File: core/wcr_regs.sv */
// Overview of operation
// RQ1: bit 0 of alert enable register turns first channel alerts on or off.
// RQ2: bit 1 of alert enable register turns second channel alerts on or off.
// RQ3: both per-channel alert enables read zero after reset.
// RQ4: first channel upper limit is 12 bits: top nibble plus bottom byte.
// RQ5: first channel lower limit is 12 bits: top nibble plus bottom byte.
// RQ6: second channel upper limit is 12 bits: top nibble plus bottom byte.
// RQ7: second channel lower limit is 12 bits: top nibble plus bottom byte.
// RQ8: six-bit hysteresis in bits 5..0 serves both first channel comparators.
// RQ9: separate six-bit hysteresis serves both second channel comparators.
// RQ10: unused upper bits of these registers read zero and ignore writes.
// RQ11: one block enable bit gates the whole comparator, apart from alerts.
// RQ12: limits reset to zero; writing one half changes only that half.
`timescale 1ns/1ps
`default_nettype none
`include "wcr_params.svh"

module wcr_regs
    import wcr_pkg::*;
#(
    parameter int unsigned NUM_CH = 2,
    parameter int unsigned LIMIT_W = 12
) (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // register access from the serial front end
    input wire wcr_req_s reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // configuration to the comparator
    output logic comparator_block_on,
    output wcr_chan_cfg_s first_channel,
    output wcr_chan_cfg_s second_channel
);

    // the field map below is fixed; other sizes are refused when built
    if (NUM_CH != 2 || LIMIT_W != 12) begin : gen_bad_config
        $error("wcr_regs serves two channels of 12-bit limits only");
    end

    // channel index 0 is the first channel, 1 the second
    logic [1:0] alert_on_ff;
    logic block_on_ff;
    logic [3:0] upper_limit_top_ff [2];
    logic [7:0] upper_limit_bottom_ff [2];
    logic [3:0] lower_limit_top_ff [2];
    logic [7:0] lower_limit_bottom_ff [2];
    logic [5:0] hysteresis_ff [2];
    logic [7:0] nxt_rdata;

    // zero-extend a top nibble to a register byte
    function automatic logic [7:0] top_byte(input logic [3:0] nib);
        top_byte = {4'h0, nib};
    endfunction

    // join halves into one limit
    function automatic wcr_limit_t join_limit(input logic [3:0] top,
                                             input logic [7:0] bot);
        join_limit = {top, bot};
    endfunction

    // per-channel enables; only the two low bits exist
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            alert_on_ff <= `WCR_RST_ALERT_EN; // see RQ3
        end else if (reg_req.wr &&
                     reg_req.addr == `WCR_ADDR_CHAN_ALERT_EN) begin
            alert_on_ff[0] <= reg_req.wdata[`WCR_BIT_FIRST_ALERT]; // see RQ1
            alert_on_ff[1] <= reg_req.wdata[`WCR_BIT_SECOND_ALERT]; // see RQ2
        end
    end

    // block enable, kept apart from the channel enables
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            block_on_ff <= `WCR_RST_BLOCK_EN;
        end else if (reg_req.wr && reg_req.addr == `WCR_ADDR_BLOCK_EN) begin
            block_on_ff <= reg_req.wdata[`WCR_BIT_BLOCK_ON]; // see RQ11
        end
    end

    // limits: each half has its own address so a write touches one half
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 2; i++) begin
                upper_limit_top_ff[i] <= `WCR_RST_LIMIT_TOP; // see RQ12
                upper_limit_bottom_ff[i] <= `WCR_RST_LIMIT_BOT;
                lower_limit_top_ff[i] <= `WCR_RST_LIMIT_TOP;
                lower_limit_bottom_ff[i] <= `WCR_RST_LIMIT_BOT;
            end
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                `WCR_ADDR_CH0_HI_BOT: begin
                    upper_limit_bottom_ff[0] <= reg_req.wdata; // see RQ4
                end
                `WCR_ADDR_CH0_HI_TOP: begin
                    // upper bits dropped on write, see RQ10
                    upper_limit_top_ff[0] <=
                        reg_req.wdata[`WCR_TOP_MSB:0]; // see RQ4
                end
                `WCR_ADDR_CH0_LO_BOT: begin
                    lower_limit_bottom_ff[0] <= reg_req.wdata; // see RQ5
                end
                `WCR_ADDR_CH0_LO_TOP: begin
                    lower_limit_top_ff[0] <=
                        reg_req.wdata[`WCR_TOP_MSB:0]; // see RQ5
                end
                `WCR_ADDR_CH1_HI_BOT: begin
                    upper_limit_bottom_ff[1] <= reg_req.wdata; // see RQ6
                end
                `WCR_ADDR_CH1_HI_TOP: begin
                    upper_limit_top_ff[1] <=
                        reg_req.wdata[`WCR_TOP_MSB:0]; // see RQ6
                end
                `WCR_ADDR_CH1_LO_BOT: begin
                    lower_limit_bottom_ff[1] <= reg_req.wdata; // see RQ7
                end
                `WCR_ADDR_CH1_LO_TOP: begin
                    lower_limit_top_ff[1] <=
                        reg_req.wdata[`WCR_TOP_MSB:0]; // see RQ7
                end
                default: begin
                end
            endcase
        end
    end

    // hysteresis, one per channel
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hysteresis_ff[0] <= `WCR_RST_HYS;
            hysteresis_ff[1] <= `WCR_RST_HYS;
        end else if (reg_req.wr) begin
            if (reg_req.addr == `WCR_ADDR_CH0_HYS) begin
                hysteresis_ff[0] <= reg_req.wdata[`WCR_HYS_MSB:0]; // see RQ8
            end
            if (reg_req.addr == `WCR_ADDR_CH1_HYS) begin
                hysteresis_ff[1] <= reg_req.wdata[`WCR_HYS_MSB:0]; // see RQ9
            end
        end
    end

    // read mux; unmapped and reserved bits return zero
    always_comb begin
        case (reg_req.addr)
            `WCR_ADDR_CHAN_ALERT_EN: begin
                nxt_rdata = {6'h00, alert_on_ff}; // see RQ10
            end
            `WCR_ADDR_BLOCK_EN: begin
                nxt_rdata = {7'h00, block_on_ff};
            end
            `WCR_ADDR_CH0_HI_BOT: begin
                nxt_rdata = upper_limit_bottom_ff[0];
            end
            `WCR_ADDR_CH0_HI_TOP: begin
                nxt_rdata = top_byte(upper_limit_top_ff[0]); // see RQ10
            end
            `WCR_ADDR_CH0_LO_BOT: begin
                nxt_rdata = lower_limit_bottom_ff[0];
            end
            `WCR_ADDR_CH0_LO_TOP: begin
                nxt_rdata = top_byte(lower_limit_top_ff[0]);
            end
            `WCR_ADDR_CH1_HI_BOT: begin
                nxt_rdata = upper_limit_bottom_ff[1];
            end
            `WCR_ADDR_CH1_HI_TOP: begin
                nxt_rdata = top_byte(upper_limit_top_ff[1]);
            end
            `WCR_ADDR_CH1_LO_BOT: begin
                nxt_rdata = lower_limit_bottom_ff[1];
            end
            `WCR_ADDR_CH1_LO_TOP: begin
                nxt_rdata = top_byte(lower_limit_top_ff[1]);
            end
            `WCR_ADDR_CH0_HYS: begin
                nxt_rdata = {2'h0, hysteresis_ff[0]}; // see RQ10
            end
            `WCR_ADDR_CH1_HYS: begin
                nxt_rdata = {2'h0, hysteresis_ff[1]};
            end
            default: begin
                nxt_rdata = `WCR_RST_RDATA;
            end
        endcase
    end

    // registered read data keeps the serial shifter off a long mux path
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= `WCR_RST_RDATA;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd) begin
                reg_rdata <= nxt_rdata;
            end
        end
    end

    // outputs straight from the stored fields
    assign comparator_block_on = block_on_ff; // see RQ11
    assign first_channel = '{
        alert_on: alert_on_ff[0],
        upper_limit: join_limit(upper_limit_top_ff[0],
                                upper_limit_bottom_ff[0]),
        lower_limit: join_limit(lower_limit_top_ff[0],
                                lower_limit_bottom_ff[0]),
        hysteresis: hysteresis_ff[0]
    };
    assign second_channel = '{
        alert_on: alert_on_ff[1],
        upper_limit: join_limit(upper_limit_top_ff[1],
                                upper_limit_bottom_ff[1]),
        lower_limit: join_limit(lower_limit_top_ff[1],
                                lower_limit_bottom_ff[1]),
        hysteresis: hysteresis_ff[1]
    };

endmodule

`default_nettype wire

/* File: verif/wcr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module wcr_host_model
    import wcr_pkg::*;
(
    // clock
    input wire logic mclk,
    // register access
    output var wcr_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial reg_req = '0;
    // one-cycle strobe; idle bus shows inverted leftovers, never stale data
    task automatic access(input logic wr, input logic [7:0] a, d);
        @(posedge mclk);
        reg_req <= '{wr, !wr, a, d};
        @(posedge mclk);
        reg_req <= '{1'b0, 1'b0, ~a, ~d};
        @(negedge mclk);
    endtask
endmodule
`default_nettype wire

/* File: verif/wcr_regs_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module wcr_regs_properties
    import wcr_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // register access
    input wire wcr_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // configuration
    input wire logic comparator_block_on,
    input wire wcr_chan_cfg_s first_channel,
    input wire wcr_chan_cfg_s second_channel
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    wire logic w = reg_req.wr;
    wire logic [7:0] a = reg_req.addr;
    wire logic [7:0] d = reg_req.wdata;
    AST_RVALID: assert property (reg_rvalid == $past(reg_req.rd))
        else $error("read answer late");
    AST_ALERT: assert property (w && a == 8'h34 |=>
        {second_channel.alert_on, first_channel.alert_on} == $past(d[1:0]))
        else $error("alert enables");
    AST_TOP0: assert property (w && a == 8'h39 |=>
        first_channel.upper_limit[11:8] == $past(d[3:0])) else $error("t0");
    AST_BOT0: assert property (w && a == 8'h3a |=>
        first_channel.lower_limit[7:0] == $past(d)) else $error("b0");
    AST_TOP1: assert property (w && a == 8'h3d |=>
        second_channel.upper_limit[11:8] == $past(d[3:0])) else $error("t1");
    AST_BOT1: assert property (w && a == 8'h3e |=>
        second_channel.lower_limit[7:0] == $past(d)) else $error("b1");
    AST_HYS0: assert property (w && a == 8'h40 |=>
        first_channel.hysteresis == $past(d[5:0])) else $error("h0");
    AST_HYS1: assert property (w && a == 8'h41 |=>
        second_channel.hysteresis == $past(d[5:0])) else $error("h1");
    AST_RSVD: assert property (reg_req.rd && a == 8'h40 |=>
        reg_rdata[7:6] == 2'b00) else $error("reserved bits");
    AST_BLOCK: assert property (w && a == 8'h37 |=>
        comparator_block_on == $past(d[0])) else $error("block enable");
    AST_HALF: assert property (w && a == 8'h38 |=>
        $stable(first_channel.upper_limit[11:8])) else $error("half");
    cover property (w && a == 8'h34);
    cover property (reg_req.rd ##1 reg_rvalid);
    cover property (w && a == 8'h41);
endmodule
`default_nettype wire

/* File: verif/window_comparator_config_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module window_comparator_config_regs_tb;
    import wcr_pkg::*;
    logic mclk;
    logic arst_n;
    wcr_req_s reg_req;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic comparator_block_on;
    wcr_chan_cfg_s first_channel;
    wcr_chan_cfg_s second_channel;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    localparam logic [7:0] ADDRS [12] = '{8'h34, 8'h37, 8'h38, 8'h39,
        8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41};
    localparam logic [7:0] MASKS [12] = '{8'h03, 8'h01, 8'hff, 8'h0f,
        8'hff, 8'h0f, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'h3f, 8'h3f};
    localparam logic [7:0] VALS [9] = '{8'ha3, 8'h3c, 8'hf1, 8'h96,
        8'h08, 8'hc3, 8'h77, 8'hd5, 8'hea};
    wcr_regs wcr_regs_i (.mclk(mclk), .arst_n(arst_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .comparator_block_on(comparator_block_on),
        .first_channel(first_channel), .second_channel(second_channel));
    wcr_host_model wcr_host_model_i (.mclk(mclk), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    task automatic check(input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        wcr_host_model_i.access(1'b1, a, d);
    endtask
    // answer stands one cycle, so it is looked at in that cycle
    task automatic rd(input logic [7:0] a, exp);
        wcr_host_model_i.access(1'b0, a, 8'h00);
        check({reg_rvalid, reg_rdata}, {1'b1, exp});
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        arst_n = 1'b0;
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        check(first_channel.alert_on, 1'b0);
        check(second_channel.alert_on, 1'b0);
        for (int i = 0; i < 12; i++) rd(ADDRS[i], 8'h00);
        for (int i = 0; i < 12; i++) wr(ADDRS[i], 8'hff);
        for (int i = 0; i < 12; i++) rd(ADDRS[i], MASKS[i]);
        check(comparator_block_on, 1'b1);
        wr(8'h37, 8'hfe);
        check(comparator_block_on, 1'b0);
        wr(8'h34, 8'h01);
        check(first_channel.alert_on, 1'b1);
        check(second_channel.alert_on, 1'b0);
        wr(8'h34, 8'h02);
        check(first_channel.alert_on, 1'b0);
        check(second_channel.alert_on, 1'b1);
        wr(8'h38, 8'h5a);
        check(first_channel.upper_limit, 12'hf5a);
        for (int i = 0; i < 9; i++) wr(8'h39 + 8'(i), VALS[i]);
        check(first_channel.upper_limit, 12'h35a);
        check(first_channel.lower_limit, 12'h13c);
        check(first_channel.hysteresis, 6'h15);
        check(second_channel.upper_limit, 12'h896);
        check(second_channel.lower_limit, 12'h7c3);
        check(second_channel.hysteresis, 6'h2a);
        wr(8'h35, 8'hff);
        rd(8'h35, 8'h00);
        // a second reset in mid-run must clear every limit again
        wr(8'h37, 8'h01);
        @(posedge mclk);
        arst_n <= 1'b0;
        @(negedge mclk);
        check(second_channel, 0);
        check(first_channel, 0);
        check(comparator_block_on, 1'b0);
        @(posedge mclk);
        arst_n <= 1'b1;
        rd(8'h34, 8'h00);
        complete_run();
    end
endmodule
bind wcr_regs wcr_regs_properties wcr_regs_properties_i (.mclk, .arst_n,
    .reg_req, .reg_rdata, .reg_rvalid, .comparator_block_on,
    .first_channel, .second_channel);
`default_nettype wire
